// [pcg_pll_ctrl.sv]
// module: pll clock generator control and status registers on apb
//
// What this block does
// - lock toggle in auto mode sets change flag; flag with enable raises interrupt
// - manual bandwidth mode: irq enable ignores writes and reads zero
// - manual bandwidth mode: change flag reads zero
// - any read of pll_control clears the change flag
// - power on bit runs loop and vco clock; clear stops both
// - reset sets power on, clears irq enable and change flag
// - power on cannot be cleared while vco drives base clock
// - base select cannot be set while power on is clear
// - base clock out is selected source divided by two
// - output held static up to three crystal and three vco cycles
// - reset and stop instruction clear base select
// - low four bits of pll_control read as ones
// - bandwidth auto bit read/write, one automatic, reset clears
// - lock bit reads lock in auto mode, zero in manual
// - acquisition bit reads loop state in auto, writable in manual
// - manual acquisition value kept during auto and restored after
// - reset clears acquisition bit
// - crystal loss: write one, wait four times n, read result
// - crystal loss bit reads zero while base select is clear
// - upper nibble of programming sets multiplier, zero acts as one
// - reset loads multiplier with six
// - lower nibble of programming holds linear range multiplier
// - linear range zero disables loop and forces crystal source
`timescale 1ns/1ps
module pcg_pll_ctrl (
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        crystal_clock,
   input  wire logic        vco_clock,
   input  wire logic        lock_detect,
   input  wire logic        loop_tracking,
   input  wire logic        stop_exec,
   output logic             base_clock_out,
   output logic             loop_power_on,
   output logic      [3:0]  feedback_multiplier,
   output logic      [3:0]  linear_range,
   output logic             bandwidth_auto,
   output logic             acquisition_not,
   output logic             clock_gen_irq
);

   // ----------------------------------------
   // state
   // ----------------------------------------
   typedef struct packed {
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic        irq_en;
      logic        flag;
      logic        pon;
      logic        bsel;
      logic        bw_auto;
      logic        acq_man;
      logic        xloss;
      logic        xl_busy;
      logic        xtal_seen;
      logic [5:0]  xl_cnt;
      logic [3:0]  mul;
      logic [3:0]  lin;
      logic        app_sel;
      logic [1:0]  xcnt;
      logic [1:0]  vcnt;
      logic        clk_out;
      logic        irq;
      logic        pon_out;
   } pcg_state_t;

   pcg_state_t st_ff;
   pcg_state_t nxt_st;

   logic xclk_rise;
   logic vclk_rise;
   logic lock_lvl;
   logic lock_tgl;
   logic track_lvl;
   logic stop_lvl;

   // ----------------------------------------
   // synchronisers for outside levels
   // ----------------------------------------
   // source clocks are oversampled: each must run below half of pclk
   pcg_edge_sync u_xclk (
      .clk    (pclk),
      .rst_n  (presetn),
      .din    (crystal_clock),
      .level  (),
      .rise   (xclk_rise),
      .toggle ()
   );

   pcg_edge_sync u_vclk (
      .clk    (pclk),
      .rst_n  (presetn),
      .din    (vco_clock),
      .level  (),
      .rise   (vclk_rise),
      .toggle ()
   );

   pcg_edge_sync u_lock (
      .clk    (pclk),
      .rst_n  (presetn),
      .din    (lock_detect),
      .level  (lock_lvl),
      .rise   (),
      .toggle (lock_tgl)
   );

   pcg_edge_sync u_track (
      .clk    (pclk),
      .rst_n  (presetn),
      .din    (loop_tracking),
      .level  (track_lvl),
      .rise   (),
      .toggle ()
   );

   // stop acts on its synced rising edge only, so a stop line
   // held high clears base select once and then lets it be set again
   pcg_edge_sync u_stop (
      .clk    (pclk),
      .rst_n  (presetn),
      .din    (stop_exec),
      .level  (),
      .rise   (stop_lvl),
      .toggle ()
   );

   // ----------------------------------------
   // next state
   // ----------------------------------------
   logic        acc_start;
   logic        acc_done;
   logic        wr_done;
   logic        rd_done;
   logic        lin_zero;
   logic        sel_eff;
   logic        acq_view;
   logic [3:0]  mul_eff;
   logic [5:0]  xl_limit;
   logic [7:0]  rd_byte;
   logic        rd_hit;
   logic [11:0] addr;
   logic        xtal_ok;
   logic        vco_ok;

   always_comb begin
      nxt_st    = st_ff;
      addr      = paddr;
      acc_start = psel & penable & ~st_ff.pready;
      acc_done  = psel & penable & st_ff.pready;
      wr_done   = acc_done & pwrite;
      rd_done   = acc_done & ~pwrite;
      lin_zero  = (st_ff.lin == 4'h0);
      mul_eff   = (st_ff.mul == pcg_pkg::MUL_ZERO) ? pcg_pkg::MUL_ONE
                                                   : st_ff.mul;
      xl_limit  = {mul_eff, pcg_pkg::XLOSS_MUL_SHIFT'(2'h0)};
      acq_view  = st_ff.bw_auto ? track_lvl : st_ff.acq_man;
      rd_byte   = 8'h00;
      rd_hit    = 1'b1;

      // ----------------------------------------
      // read mux; unmapped offsets answer with an error
      // ----------------------------------------
      if (addr == pcg_pkg::PLL_CONTROL_OFS) begin
         rd_byte[pcg_pkg::CTL_IRQ_ENABLE_BIT]  = st_ff.irq_en & st_ff.bw_auto;
         rd_byte[pcg_pkg::CTL_CHANGE_FLAG_BIT] = st_ff.flag & st_ff.bw_auto;
         rd_byte[pcg_pkg::CTL_POWER_ON_BIT]    = st_ff.pon;
         rd_byte[pcg_pkg::CTL_BASE_SEL_BIT]    = st_ff.bsel;
         rd_byte[3:0]                          = pcg_pkg::CTL_LOW_NIBBLE_READ;
      end else if (addr == pcg_pkg::PLL_BANDWIDTH_CONTROL_OFS) begin
         rd_byte[pcg_pkg::BWC_AUTO_BIT]  = st_ff.bw_auto;
         rd_byte[pcg_pkg::BWC_LOCK_BIT]  = lock_lvl & st_ff.bw_auto;
         rd_byte[pcg_pkg::BWC_ACQ_BIT]   = acq_view;
         rd_byte[pcg_pkg::BWC_XLOSS_BIT] = st_ff.xloss & st_ff.bsel;
         rd_byte[3:0]                    = pcg_pkg::BWC_TEST_READ;
      end else if (addr == pcg_pkg::PLL_PROGRAMMING_OFS) begin
         rd_byte[pcg_pkg::PPG_MUL_LSB +: 4] = st_ff.mul;
         rd_byte[pcg_pkg::PPG_LIN_LSB +: 4] = st_ff.lin;
      end else begin
         rd_hit = 1'b0;
      end

      // ----------------------------------------
      // apb: one wait state, data and answer registered
      // ----------------------------------------
      // registered answer costs a wait state but keeps decode off prdata
      nxt_st.pready = acc_start;
      if (acc_start) begin
         nxt_st.prdata  = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
         nxt_st.pslverr = ~rd_hit;
      end else begin
         nxt_st.prdata  = 32'h0000_0000;
         nxt_st.pslverr = 1'b0;
      end

      // ----------------------------------------
      // register writes
      // ----------------------------------------
      if (wr_done && rd_hit) begin
         if (addr == pcg_pkg::PLL_CONTROL_OFS) begin
            if (st_ff.bw_auto) begin
               nxt_st.irq_en = pwdata[pcg_pkg::CTL_IRQ_ENABLE_BIT];
            end
            // old select blocks a clear; old power off blocks a set, so a write of select
            // one and power zero can set select and clear power together
            nxt_st.pon = pwdata[pcg_pkg::CTL_POWER_ON_BIT] | st_ff.bsel;
            nxt_st.bsel = pwdata[pcg_pkg::CTL_BASE_SEL_BIT] & st_ff.pon
                          & ~lin_zero;
         end else if (addr == pcg_pkg::PLL_BANDWIDTH_CONTROL_OFS) begin
            nxt_st.bw_auto = pwdata[pcg_pkg::BWC_AUTO_BIT];
            if (!st_ff.bw_auto) begin
               nxt_st.acq_man = pwdata[pcg_pkg::BWC_ACQ_BIT];
            end
            // test bits are not stored; software keeps them zero
            if (pwdata[pcg_pkg::BWC_XLOSS_BIT]) begin
               nxt_st.xloss     = 1'b1;
               nxt_st.xl_busy   = 1'b1;
               nxt_st.xtal_seen = 1'b0;
               nxt_st.xl_cnt    = 6'h00;
            end else begin
               // writing zero drops the result and cancels a pending window
               nxt_st.xloss     = 1'b0;
               nxt_st.xl_busy   = 1'b0;
            end
         end else begin
            nxt_st.mul = pwdata[pcg_pkg::PPG_MUL_LSB +: 4];
            nxt_st.lin = pwdata[pcg_pkg::PPG_LIN_LSB +: 4];
         end
      end

      // linear range zero or stop pulls the base back to the crystal
      if (lin_zero || stop_lvl) begin
         nxt_st.bsel = 1'b0;
      end

      // ----------------------------------------
      // lock change flag; set beats the read clear
      // ----------------------------------------
      if (rd_done && addr == pcg_pkg::PLL_CONTROL_OFS) begin
         nxt_st.flag = 1'b0;
      end
      if (lock_tgl && st_ff.bw_auto) begin
         nxt_st.flag = 1'b1;
      end
      // manual mode keeps the request quiet, as the masked enable reads
      nxt_st.irq = st_ff.flag & st_ff.irq_en & st_ff.bw_auto;

      // ----------------------------------------
      // crystal loss window counted in vco edges
      // ----------------------------------------
      // limitation: with the vco stopped the window never closes
      if (st_ff.xl_busy && !(wr_done && addr == pcg_pkg::PLL_BANDWIDTH_CONTROL_OFS)) begin
         if (xclk_rise) begin
            nxt_st.xtal_seen = 1'b1;
         end
         if (vclk_rise) begin
            nxt_st.xl_cnt = st_ff.xl_cnt + 6'h01;
            if (st_ff.xl_cnt + 6'h01 >= xl_limit) begin
               nxt_st.xl_busy = 1'b0;
               nxt_st.xloss   = ~(st_ff.xtal_seen | xclk_rise);
            end
         end
      end

      // ----------------------------------------
      // base clock: transition hold, then divide by two
      // ----------------------------------------
      sel_eff = st_ff.bsel & ~lin_zero;
      xtal_ok = (st_ff.xcnt == pcg_pkg::TRANS_EDGES);
      // a loop that is off gives no vco edges, so leaving it must not wait
      vco_ok  = (st_ff.vcnt == pcg_pkg::TRANS_EDGES) | ~st_ff.pon_out;
      if (sel_eff != st_ff.app_sel) begin
         // output stays put until the crystal, and the vco while the loop is powered, has ticked three times
         if (xclk_rise && st_ff.xcnt != pcg_pkg::TRANS_EDGES) begin
            nxt_st.xcnt = st_ff.xcnt + 2'h1;
         end
         if (vclk_rise && st_ff.vcnt != pcg_pkg::TRANS_EDGES) begin
            nxt_st.vcnt = st_ff.vcnt + 2'h1;
         end
         if (xtal_ok && vco_ok) begin
            nxt_st.app_sel = sel_eff;
            nxt_st.xcnt    = 2'h0;
            nxt_st.vcnt    = 2'h0;
         end
      end else begin
         nxt_st.xcnt = 2'h0;
         nxt_st.vcnt = 2'h0;
         if (st_ff.app_sel ? vclk_rise : xclk_rise) begin
            nxt_st.clk_out = ~st_ff.clk_out;
         end
      end

      // one cycle behind the bit, so the pin leaves a flop
      nxt_st.pon_out = st_ff.pon & ~lin_zero;
   end

   // ----------------------------------------
   // state register
   // ----------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_ff           <= '0;
         // loop starts powered so it can settle during power-up
         st_ff.pon       <= pcg_pkg::PON_RST;
         st_ff.mul       <= pcg_pkg::MUL_RST;
         st_ff.lin       <= pcg_pkg::LIN_RST;
         st_ff.bw_auto   <= pcg_pkg::BW_AUTO_RST;
         st_ff.acq_man   <= pcg_pkg::ACQ_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // ----------------------------------------
   // outputs, all from flops
   // ----------------------------------------
   assign prdata              = st_ff.prdata;
   assign pready              = st_ff.pready;
   assign pslverr             = st_ff.pslverr;
   assign base_clock_out      = st_ff.clk_out;
   assign loop_power_on       = st_ff.pon_out;
   assign feedback_multiplier = st_ff.mul;
   assign linear_range        = st_ff.lin;
   assign bandwidth_auto      = st_ff.bw_auto;
   assign acquisition_not     = st_ff.acq_man;
   assign clock_gen_irq       = st_ff.irq;

endmodule

// [pcg_pkg.sv]
// package: register map, field positions, reset values and counts for the pll control block
package pcg_pkg;

   // ----------------------------------------
   // register offsets (byte addresses)
   // ----------------------------------------
   localparam logic [11:0] PLL_CONTROL_OFS           = 12'h000;
   localparam logic [11:0] PLL_BANDWIDTH_CONTROL_OFS = 12'h004;
   localparam logic [11:0] PLL_PROGRAMMING_OFS       = 12'h008;

   // ----------------------------------------
   // pll_control fields
   // ----------------------------------------
   localparam int CTL_IRQ_ENABLE_BIT = 7;
   localparam int CTL_CHANGE_FLAG_BIT = 6;
   localparam int CTL_POWER_ON_BIT   = 5;
   localparam int CTL_BASE_SEL_BIT   = 4;
   localparam logic [3:0] CTL_LOW_NIBBLE_READ = 4'hF;

   // ----------------------------------------
   // pll_bandwidth_control fields
   // ----------------------------------------
   localparam int BWC_AUTO_BIT     = 7;
   localparam int BWC_LOCK_BIT     = 6;
   localparam int BWC_ACQ_BIT      = 5;
   localparam int BWC_XLOSS_BIT    = 4;
   localparam logic [3:0] BWC_TEST_READ = 4'h0;

   // ----------------------------------------
   // pll_programming fields
   // ----------------------------------------
   localparam int PPG_MUL_LSB = 4;
   localparam int PPG_LIN_LSB = 0;

   // ----------------------------------------
   // reset values
   // ----------------------------------------
   localparam logic       PON_RST      = 1'b1;
   localparam logic [3:0] MUL_RST      = 4'h6;
   localparam logic [3:0] LIN_RST      = 4'h1;
   localparam logic       BW_AUTO_RST  = 1'b0;
   localparam logic       ACQ_RST      = 1'b0;

   // ----------------------------------------
   // counts
   // ----------------------------------------
   localparam logic [1:0] TRANS_EDGES     = 2'h3;
   localparam logic [1:0] XLOSS_MUL_SHIFT = 2'h2;
   localparam logic [3:0] MUL_ZERO        = 4'h0;
   localparam logic [3:0] MUL_ONE         = 4'h1;

endpackage

// [pcg_edge_sync.sv]
// module: two-stage synchroniser with edge detect for an outside level
`timescale 1ns/1ps
module pcg_edge_sync (
   input  wire logic clk,
   input  wire logic rst_n,
   input  wire logic din,
   output logic      level,
   output logic      rise,
   output logic      toggle
);

   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
   } pcg_sync_t;

   pcg_sync_t sy_ff;
   pcg_sync_t nxt_sy;

   // ----------------------------------------
   // synchroniser; s1 feeds s2 only
   // ----------------------------------------
   always_comb begin
      nxt_sy    = sy_ff;
      nxt_sy.s1 = din;
      nxt_sy.s2 = sy_ff.s1;
      nxt_sy.s3 = sy_ff.s2;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         sy_ff <= '0;
      end else begin
         sy_ff <= nxt_sy;
      end
   end

   assign level  = sy_ff.s2;
   assign rise   = sy_ff.s2 & ~sy_ff.s3;
   assign toggle = sy_ff.s2 ^ sy_ff.s3;

endmodule

// [pcg_pll_ctrl_checker.sv]
// checker: apb and register read relations of the pll control block
`timescale 1ns/1ps
module pcg_pll_ctrl_checker (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [3:0]  feedback_multiplier,
   input wire logic [3:0]  linear_range,
   input wire logic        bandwidth_auto,
   input wire logic        acquisition_not,
   input wire logic        clock_gen_irq
);
   // ----------------------------------------
   // read qualifiers
   // ----------------------------------------
   logic rd_ok;
   logic rd_ctl;
   logic rd_bwc;
   logic rd_ppg;
   assign rd_ok  = pready && !pwrite && !pslverr;
   assign rd_ctl = rd_ok && paddr == pcg_pkg::PLL_CONTROL_OFS;
   assign rd_bwc = rd_ok && paddr == pcg_pkg::PLL_BANDWIDTH_CONTROL_OFS;
   assign rd_ppg = rd_ok && paddr == pcg_pkg::PLL_PROGRAMMING_OFS;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   wait_state_a: assert property (psel && $rose(penable) |=> pready && penable)
      else $error("pready not one cycle after access start");
   pready_pulse_a: assert property (pready |=> !pready)
      else $error("pready held longer than one cycle");
   idle_data_a: assert property (!pready |-> prdata == 32'h0000_0000)
      else $error("read data not zero outside answer");
   slverr_data_a: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
      else $error("error answer malformed");
   ctl_ones_a: assert property (rd_ctl |-> prdata[3:0] == 4'hF)
      else $error("control low nibble not ones");
   sel_needs_on_a: assert property (rd_ctl && prdata[4] |-> prdata[5])
      else $error("base select set with loop off");
   test_bits_a: assert property (rd_bwc |-> prdata[3:0] == 4'h0)
      else $error("test bits not zero");
   lock_manual_a: assert property (rd_bwc && !prdata[7] |-> !prdata[6])
      else $error("lock seen in manual mode");
   auto_echo_a: assert property (rd_bwc |-> prdata[7] == bandwidth_auto)
      else $error("auto bit and output differ");
   acq_manual_a: assert property (rd_bwc && !prdata[7] |-> prdata[5] == acquisition_not)
      else $error("manual acquisition readback wrong");
   ppg_out_a: assert property (rd_ppg |-> prdata[7:0] == {feedback_multiplier, linear_range})
      else $error("programming fields and outputs differ");
   reset_vals_a: assert property ($rose(presetn) |->
      feedback_multiplier == 4'h6 && !bandwidth_auto && !acquisition_not
      && !clock_gen_irq)
      else $error("reset values wrong");
endmodule

// [pcg_pll_ctrl_bench.sv]
// testbench: directed scenarios for the pll control block over apb
`timescale 1ns/1ps
module pcg_pll_ctrl_bench;
   localparam logic [11:0] CT = pcg_pkg::PLL_CONTROL_OFS;
   localparam logic [11:0] BW = pcg_pkg::PLL_BANDWIDTH_CONTROL_OFS;
   localparam logic [11:0] PG = pcg_pkg::PLL_PROGRAMMING_OFS;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic        crystal_clock = 0, vco_clock = 0, lock_detect = 0;
   logic        loop_tracking = 0, stop_exec = 0, x_run = 1;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0000_0000;
   wire  [31:0] prdata;
   wire  [3:0]  feedback_multiplier, linear_range;
   wire         pready, pslverr, base_clock_out, loop_power_on;
   wire         bandwidth_auto, acquisition_not, clock_gen_irq;
   int          n_fail = 0, checks_done = 0, cnt = 0;
   pcg_pll_ctrl pcg_pll_ctrl_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .crystal_clock(crystal_clock), .vco_clock(vco_clock), .lock_detect(lock_detect),
      .loop_tracking(loop_tracking), .stop_exec(stop_exec),
      .base_clock_out(base_clock_out), .loop_power_on(loop_power_on),
      .feedback_multiplier(feedback_multiplier), .linear_range(linear_range),
      .bandwidth_auto(bandwidth_auto), .acquisition_not(acquisition_not),
      .clock_gen_irq(clock_gen_irq));
   initial begin
      forever #4 pclk = ~pclk;
   end
   // slow source clocks, below pclk/2 so the synchronisers see them
   always @(posedge pclk) begin
      cnt <= cnt + 1;
      if (x_run && cnt % 4 == 0) crystal_clock <= ~crystal_clock;
      if (cnt % 3 == 0) vco_clock <= ~vco_clock;
   end
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   task chk(input logic [31:0] g, input logic [31:0] e);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [7:0] d,
            output logic [31:0] r, output logic er);
      int n;
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a;
      pwdata <= {24'h00_0000, d};
      @(posedge pclk);
      penable <= 1;
      n = 0;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      r = prdata;
      er = pslverr;
      if (n >= 20) chk(0, 1);
      psel <= 0; penable <= 0;
   endtask
   task wr(input logic [11:0] a, input logic [7:0] d);
      logic [31:0] r;
      logic er;
      apb(1, a, d, r, er);
      chk({31'h0, er}, 0);
   endtask
   task rd(input logic [11:0] a, input logic [7:0] e);
      logic [31:0] r;
      logic er;
      apb(0, a, 8'h00, r, er);
      chk(r, {24'h00_0000, e});
      chk({31'h0, er}, 0);
   endtask
   // counts output changes over len cycles: /2 of the source
   task edges(input int lo, input int hi, input int len);
      int n;
      logic p;
      n = 0;
      p = base_clock_out;
      repeat (len) begin
         @(posedge pclk);
         if (base_clock_out !== p) n++;
         p = base_clock_out;
      end
      chk({31'h0, n >= lo && n <= hi}, 1);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task t_reset;
      logic [31:0] r;
      logic er;
      rd(CT, 8'h2F);
      rd(BW, 8'h00);
      rd(PG, 8'h61);
      apb(0, 12'h00C, 8'h00, r, er);
      chk(r, 0);
      chk({31'h0, er}, 1);
      edges(11, 13, 96);
   endtask
   task t_manual;
      wr(CT, 8'hE0);
      rd(CT, 8'h2F);
      lock_detect <= 1;
      repeat (8) @(posedge pclk);
      rd(CT, 8'h2F);
      chk({31'h0, clock_gen_irq}, 0);
      wr(BW, 8'h20);
      rd(BW, 8'h20);
   endtask
   task t_auto;
      wr(BW, 8'hA0);
      rd(BW, 8'hC0);
      loop_tracking <= 1;
      repeat (4) @(posedge pclk);
      rd(BW, 8'hE0);
      loop_tracking <= 0;
      wr(CT, 8'hA0);
      lock_detect <= 0;
      repeat (8) @(posedge pclk);
      chk({31'h0, clock_gen_irq}, 1);
      rd(CT, 8'hEF);
      rd(CT, 8'hAF);
      repeat (3) @(posedge pclk);
      chk({31'h0, clock_gen_irq}, 0);
      lock_detect <= 1;
      repeat (8) @(posedge pclk);
      chk({31'h0, clock_gen_irq}, 1);
      wr(BW, 8'h00);
      rd(CT, 8'h2F);
      rd(BW, 8'h20);
   endtask
   task t_switch;
      wr(CT, 8'h00);
      repeat (3) @(posedge pclk);
      chk({31'h0, loop_power_on}, 0);
      wr(CT, 8'h10);
      rd(CT, 8'h0F);
      wr(CT, 8'h20);
      wr(CT, 8'h30);
      edges(0, 1, 16);
      chk({31'h0, loop_power_on}, 1);
      wr(CT, 8'h10);
      rd(CT, 8'h3F);
      repeat (40) @(posedge pclk);
      edges(15, 17, 96);
      wr(BW, 8'h10);
      repeat (200) @(posedge pclk);
      rd(BW, 8'h00);
      x_run <= 0;
      wr(BW, 8'h10);
      repeat (200) @(posedge pclk);
      rd(BW, 8'h10);
      x_run <= 1;
      stop_exec <= 1;
      repeat (6) @(posedge pclk);
      stop_exec <= 0;
      rd(CT, 8'h2F);
      rd(BW, 8'h00);
   endtask
   task t_linear;
      wr(PG, 8'h60);
      repeat (3) @(posedge pclk);
      chk({31'h0, loop_power_on}, 0);
      wr(CT, 8'h30);
      rd(CT, 8'h2F);
      rd(PG, 8'h60);
   endtask
   // ----------------------------------------
   // run control
   // ----------------------------------------
   task complete_run;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge pclk);
      presetn <= 1;
      t_reset;
      t_manual;
      t_auto;
      t_switch;
      t_linear;
      complete_run;
   end
   // whole run is under a thousand cycles
   initial begin
      #100us;
      n_fail++;
      complete_run;
   end
endmodule
bind pcg_pll_ctrl pcg_pll_ctrl_checker pcg_pll_ctrl_checker_inst (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .feedback_multiplier(feedback_multiplier), .linear_range(linear_range),
   .bandwidth_auto(bandwidth_auto), .acquisition_not(acquisition_not),
   .clock_gen_irq(clock_gen_irq));
